//--- core/dpa_packetizer.sv
// secondary-channel audio, info and extension packet builder
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`default_nettype none
// Functional notes
// R1 - audio words are 32 bits: control bits, 24-bit sample, preamble.
// R2 - a word is taken only when tvalid and tready are both high.
// R3 - packets: 4 header, 4 parity, 32 payload, 8 parity bytes.
// R4 - eight samples are collected before an audio packet is sent.
// R5 - the source puts the channel id on tid with each sample.
// R6 - info frame packet id must match tid bits 7 to 4.
// R7 - writing zero to control disables audio, flushes buffers, sets mute; the code flushes the sample buffer and the info load, not the extension buffer.
// R8 - software disables audio before changing video or audio parameters.
// R9 - info frame is eight ordered writes, stored in arrival order.
// R10 - channel count register holds channels minus one.
// R11 - synchronous mode sends host-written audio ratio values.
// R12 - writing one to control enables audio transmission.
// R13 - info packet is sent once per frame or every 8192 cycles.
// R14 - software disables audio before changing the info packet.
// R15 - re-programming: disable, wait for stable clocks, enable, wait.
// R16 - one extension buffer, sent at first free secondary slot.
// R17 - extension packet is eight 32-bit words.
// R18 - a sent pulse follows each extension packet; software waits for it.
// R19 - asynchronous mode measures audio ratio from the 512 fs clock.
// R20 - misc bit 0 set: send host-programmed video ratio values.
// R21 - misc bit 0 clear: fixed denominator, numerator from clocking input.
// R22 - while disabled tready is low and no audio packet starts.
module dpa_packetizer
	import dpa_pkg::*;
#(
	parameter int INFO_PERIOD = INFO_PERIOD_CYC,
	parameter int AUD_WINDOW = AUD_N_WINDOW_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	input wire logic [31:0] s_axis_audio_tdata,
	input wire logic [7:0] s_axis_audio_tid,
	input wire logic s_axis_audio_tvalid,
	output logic s_axis_audio_tready,
	input wire logic aud_ref_clk,
	input wire logic frame_start,
	input wire logic [23:0] vid_m_in,
	output logic [7:0] pkt_data,
	output logic pkt_valid,
	output logic pkt_sop,
	output logic pkt_eop,
	input wire logic pkt_ready,
	output logic vertical_blank_identifier_mute,
	output logic extension_packet_sent_irq,
	output logic [23:0] vid_m_out,
	output logic [23:0] vid_n_out,
	output logic [23:0] audio_m_value,
	output logic [23:0] audio_n_value
);
	// byte of a packet at position idx, parity bytes derived from the data
	function automatic logic [7:0] dpa_byte(input logic [5:0] idx, input logic [31:0] hdr,
		input logic [255:0] pay);
		logic [7:0] b;
		logic [4:0] pi;
		logic [2:0] pj;
		b = 8'h00;
		pi = 5'(idx - HDR_PAR_END);
		pj = 3'(idx - PAY_END);
		if (idx < HDR_END) begin
			b = hdr[8*idx[1:0] +: 8];
		end else if (idx < HDR_PAR_END) begin
			b = hdr[8*idx[1:0] +: 8] ^ hdr[8*(2'(idx[1:0] + 2'h1)) +: 8];
		end else if (idx < PAY_END) begin
			b = pay[8*pi +: 8];
		end else begin
			b = pay[8*pj +: 8] ^ pay[8*(pj+8) +: 8] ^ pay[8*(pj+16) +: 8] ^ pay[8*(pj+24) +: 8];
		end
		return b;
	endfunction : dpa_byte

	logic ctrl_en_reg;
	logic [2:0] chan_reg;
	logic misc_sync_reg;
	logic [23:0] aud_num_reg;
	logic [23:0] aud_den_reg;
	logic [23:0] vid_num_reg;
	logic [23:0] vid_den_reg;
	logic [31:0] info_mem [8];
	logic [3:0] info_ptr_reg;
	logic [31:0] ext_mem [8];
	logic [3:0] ext_ptr_reg;
	logic ext_sent_reg;
	logic sid_mismatch_reg;
	logic [31:0] samp_mem [8];
	logic [3:0] samp_cnt_reg;
	logic [7:0] first_tid_reg;
	logic info_due_reg;
	logic [13:0] info_tmr_reg;
	dpa_state_type state_reg;
	dpa_kind_type kind_reg;
	logic [5:0] idx_reg;
	logic [2:0] aref_sync_reg;
	logic [23:0] aud_edges_reg;
	logic [23:0] aud_m_meas_reg;
	logic [15:0] aud_win_reg;

	logic wr_ctrl, wr_info, wr_ext, wr_status;
	logic info_loaded, ext_full, take, byte_go, last_go;
	logic start_info, start_ext, start_audio;
	logic [31:0] cur_hdr;
	logic [255:0] cur_pay;

	assign wr_ctrl = reg_wr && (reg_addr == OFS_AUDIO_CTRL);
	assign wr_info = reg_wr && (reg_addr == OFS_INFO_DATA);
	assign wr_ext = reg_wr && (reg_addr == OFS_EXT_DATA);
	assign wr_status = reg_wr && (reg_addr == OFS_STATUS);
	assign info_loaded = (info_ptr_reg == WORDS_PER_PKT);
	assign ext_full = (ext_ptr_reg == WORDS_PER_PKT);
	// a byte only advances once it is really offered, so the load cycle never skips byte 0
	assign byte_go = pkt_valid && pkt_ready;
	assign last_go = byte_go && (idx_reg == PKT_LAST);

	// intake stalls while an audio packet drains, so the buffer never overwrites
	assign s_axis_audio_tready = ctrl_en_reg && (samp_cnt_reg < SAMPLES_PER_PKT)
		&& !((state_reg == DPA_SEND) && (kind_reg == DPA_K_AUDIO)); // R2 R22
	assign take = s_axis_audio_tvalid && s_axis_audio_tready; // R2

	// launch arbitration: info first, then extension, then audio
	assign start_info = (state_reg == DPA_IDLE) && info_due_reg && info_loaded; // R13
	assign start_ext = (state_reg == DPA_IDLE) && !start_info && ext_full; // R16
	assign start_audio = (state_reg == DPA_IDLE) && !start_info && !ext_full
		&& ctrl_en_reg && (samp_cnt_reg == SAMPLES_PER_PKT); // R4 R22

	// control and configuration registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_en_reg <= 1'b0;
			chan_reg <= 3'h0;
			misc_sync_reg <= 1'b0;
			aud_num_reg <= 24'h000000;
			aud_den_reg <= 24'h000000;
			vid_num_reg <= 24'h000000;
			vid_den_reg <= 24'h000000;
		end else if (reg_wr) begin
			unique case (reg_addr)
				OFS_AUDIO_CTRL: ctrl_en_reg <= reg_wdata[0]; // R7 R12
				OFS_CHANNELS: chan_reg <= reg_wdata[2:0]; // R10
				OFS_MISC: misc_sync_reg <= reg_wdata[0]; // R20
				OFS_AUD_NUM: aud_num_reg <= reg_wdata[23:0]; // R11
				OFS_AUD_DEN: aud_den_reg <= reg_wdata[23:0]; // R11
				OFS_VID_NUM: vid_num_reg <= reg_wdata[23:0];
				OFS_VID_DEN: vid_den_reg <= reg_wdata[23:0];
				default: ;
			endcase
		end
	end

	// info frame words land in arrival order; a disable restarts the load
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			info_ptr_reg <= 4'h0;
		end else if (wr_ctrl && !reg_wdata[0]) begin
			info_ptr_reg <= 4'h0; // R7
		end else if (wr_info && !info_loaded) begin
			info_mem[info_ptr_reg[2:0]] <= reg_wdata; // R9
			info_ptr_reg <= info_ptr_reg + 4'h1;
		end
	end

	// extension buffer: writes while full are dropped until the packet leaves
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ext_ptr_reg <= 4'h0;
		end else if (last_go && (kind_reg == DPA_K_EXT)) begin
			ext_ptr_reg <= 4'h0; // R16
		end else if (wr_ext && !ext_full) begin
			ext_mem[ext_ptr_reg[2:0]] <= reg_wdata; // R17
			ext_ptr_reg <= ext_ptr_reg + 4'h1;
		end
	end

	// sent pulse and its sticky copy; a new send beats a clear in the same cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			extension_packet_sent_irq <= 1'b0;
			ext_sent_reg <= 1'b0;
		end else begin
			extension_packet_sent_irq <= last_go && (kind_reg == DPA_K_EXT); // R18
			if (last_go && (kind_reg == DPA_K_EXT)) begin
				ext_sent_reg <= 1'b1; // R18
			end else if (wr_status && reg_wdata[ST_EXT_SENT]) begin
				ext_sent_reg <= 1'b0;
			end
		end
	end

	// sample buffer; tid is kept from the first sample of each packet
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			samp_cnt_reg <= 4'h0;
			first_tid_reg <= 8'h00;
		end else if (!ctrl_en_reg || (last_go && (kind_reg == DPA_K_AUDIO))) begin
			samp_cnt_reg <= 4'h0; // R7
		end else if (take) begin
			samp_mem[samp_cnt_reg[2:0]] <= s_axis_audio_tdata; // R1
			samp_cnt_reg <= samp_cnt_reg + 4'h1;
			if (samp_cnt_reg == 4'h0) begin
				first_tid_reg <= s_axis_audio_tid; // R5
			end
		end
	end

	// stream id check against the low nibble of the packet id byte of the first info word
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sid_mismatch_reg <= 1'b0;
		end else if (take && info_loaded && (s_axis_audio_tid[7:4] != info_mem[0][3:0])) begin
			sid_mismatch_reg <= 1'b1; // R6
		end else if (wr_status && reg_wdata[ST_SID_MISMATCH]) begin
			sid_mismatch_reg <= 1'b0;
		end
	end

	// info repeat: per frame or per period, whichever comes first
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			info_tmr_reg <= 14'h0000;
			info_due_reg <= 1'b0;
		end else begin
			if (frame_start || (info_tmr_reg == 14'(INFO_PERIOD - 1))) begin
				info_tmr_reg <= 14'h0000;
			end else begin
				info_tmr_reg <= info_tmr_reg + 14'h0001;
			end
			if (ctrl_en_reg && (frame_start || (info_tmr_reg == 14'(INFO_PERIOD - 1)))) begin
				info_due_reg <= 1'b1; // R13
			end else if (start_info || !ctrl_en_reg) begin
				info_due_reg <= 1'b0;
			end
		end
	end

	// header and payload of the packet being sent
	always_comb begin
		cur_hdr = RST_WORD;
		cur_pay = '0;
		unique case (kind_reg)
			DPA_K_AUDIO: begin
				cur_hdr = {first_tid_reg, 5'h00, chan_reg, TYPE_AUDIO, 4'h0, first_tid_reg[7:4]};
				for (int i = 0; i < 8; i++) begin
					cur_pay[32*i +: 32] = samp_mem[i];
				end
			end
			DPA_K_INFO: begin
				cur_hdr = {16'h0000, TYPE_INFO, info_mem[0][7:0]};
				for (int i = 0; i < 8; i++) begin
					cur_pay[32*i +: 32] = info_mem[i];
				end
			end
			default: begin
				cur_hdr = {16'h0000, TYPE_EXT, 8'h00};
				for (int i = 0; i < 8; i++) begin
					cur_pay[32*i +: 32] = ext_mem[i];
				end
			end
		endcase
	end

	// packet engine: one byte per accepted cycle, 48 bytes per packet
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= DPA_IDLE;
			kind_reg <= DPA_K_AUDIO;
			idx_reg <= 6'h00;
		end else begin
			unique case (state_reg)
				DPA_IDLE: begin
					idx_reg <= 6'h00;
					if (start_info) begin
						kind_reg <= DPA_K_INFO;
						state_reg <= DPA_SEND;
					end else if (start_ext) begin
						kind_reg <= DPA_K_EXT;
						state_reg <= DPA_SEND;
					end else if (start_audio) begin
						kind_reg <= DPA_K_AUDIO;
						state_reg <= DPA_SEND;
					end
				end
				DPA_SEND: begin
					if (last_go) begin
						state_reg <= DPA_IDLE; // R3
					end else if (byte_go) begin
						idx_reg <= idx_reg + 6'h01;
					end
				end
			endcase
		end
	end

	// the byte register moves with the index on an advance and catches up one cycle after a load
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pkt_data <= 8'h00;
		end else begin
			pkt_data <= dpa_byte(byte_go ? 6'(idx_reg + 6'h01) : idx_reg, cur_hdr, cur_pay); // R3
		end
	end
	// first byte is only valid after its load cycle
	logic loaded_reg;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			loaded_reg <= 1'b0;
		end else begin
			loaded_reg <= (state_reg == DPA_SEND) && !last_go;
		end
	end
	assign pkt_valid = (state_reg == DPA_SEND) && loaded_reg;
	assign pkt_sop = pkt_valid && (idx_reg == 6'h00);
	assign pkt_eop = pkt_valid && (idx_reg == PKT_LAST);

	// audio reference pin: two flops, then an edge detect on the second
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			aref_sync_reg <= 3'b000;
		end else begin
			aref_sync_reg <= {aref_sync_reg[1:0], aud_ref_clk};
		end
	end

	// count reference edges over a fixed window; limited to refs below clk/2
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			aud_win_reg <= 16'h0000;
			aud_edges_reg <= 24'h000000;
			aud_m_meas_reg <= 24'h000000;
		end else if (aud_win_reg == 16'(AUD_WINDOW - 1)) begin
			aud_win_reg <= 16'h0000;
			aud_m_meas_reg <= aud_edges_reg; // R19
			aud_edges_reg <= 24'h000000;
		end else begin
			aud_win_reg <= aud_win_reg + 16'h0001;
			if (aref_sync_reg[1] && !aref_sync_reg[2]) begin
				aud_edges_reg <= aud_edges_reg + 24'h000001;
			end
		end
	end

	// ratio outputs chosen by the clock mode bit
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			vid_m_out <= 24'h000000;
			vid_n_out <= 24'h000000;
			audio_m_value <= 24'h000000;
			audio_n_value <= 24'h000000;
		end else if (misc_sync_reg) begin
			vid_m_out <= vid_num_reg; // R20
			vid_n_out <= vid_den_reg; // R20
			audio_m_value <= aud_num_reg; // R11
			audio_n_value <= aud_den_reg; // R11
		end else begin
			vid_m_out <= vid_m_in; // R21
			vid_n_out <= VID_N_FIXED; // R21
			audio_m_value <= aud_m_meas_reg; // R19
			audio_n_value <= 24'(AUD_WINDOW); // R19
		end
	end

	// mute flag in the blanking identifier follows the enable
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			vertical_blank_identifier_mute <= 1'b1;
		end else begin
			vertical_blank_identifier_mute <= !ctrl_en_reg; // R7
		end
	end

	// read data the cycle after the strobe; unmapped offsets read zero
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= RST_WORD;
		end else if (reg_rd) begin
			unique case (reg_addr)
				OFS_AUDIO_CTRL: reg_rdata <= {31'h0, ctrl_en_reg};
				OFS_CHANNELS: reg_rdata <= {29'h0, chan_reg};
				OFS_MISC: reg_rdata <= {31'h0, misc_sync_reg};
				OFS_AUD_NUM: reg_rdata <= {8'h00, aud_num_reg};
				OFS_AUD_DEN: reg_rdata <= {8'h00, aud_den_reg};
				OFS_VID_NUM: reg_rdata <= {8'h00, vid_num_reg};
				OFS_VID_DEN: reg_rdata <= {8'h00, vid_den_reg};
				OFS_AUD_M_RD: reg_rdata <= {8'h00, aud_m_meas_reg};
				OFS_STATUS: reg_rdata <= {24'h0, samp_cnt_reg, sid_mismatch_reg, info_loaded,
					ext_full, ext_sent_reg};
				default: reg_rdata <= RST_WORD;
			endcase
		end else begin
			reg_rdata <= RST_WORD;
		end
	end

	a_ready_disabled: assert property (@(posedge clk) disable iff (!rstn) // R22
		!ctrl_en_reg |-> !s_axis_audio_tready) else $error("tready high while disabled");
	a_ready_full: assert property (@(posedge clk) disable iff (!rstn) // R4
		(samp_cnt_reg == SAMPLES_PER_PKT) |-> !s_axis_audio_tready) else $error("tready high with full buffer");
	a_mute_follow: assert property (@(posedge clk) disable iff (!rstn) // R7
		$fell(ctrl_en_reg) |=> vertical_blank_identifier_mute && (samp_cnt_reg == 4'h0))
		else $error("disable did not mute and flush");
	a_ext_pulse: assert property (@(posedge clk) disable iff (!rstn) // R18
		(pkt_eop && pkt_ready && (kind_reg == DPA_K_EXT)) |=> extension_packet_sent_irq ##1 ext_sent_reg)
		else $error("extension sent pulse missing");
	a_pkt_length: assert property (@(posedge clk) disable iff (!rstn) // R3
		(pkt_eop && pkt_ready) |-> (idx_reg == 6'h2f)) else $error("packet length wrong");
	a_audio_start: assert property (@(posedge clk) disable iff (!rstn) // R4
		$rose(state_reg == DPA_SEND) && (kind_reg == DPA_K_AUDIO) |-> (samp_cnt_reg == 4'h8))
		else $error("audio packet with fewer than eight samples");
	a_info_due: assert property (@(posedge clk) disable iff (!rstn) // R13
		(ctrl_en_reg && frame_start) |=> info_due_reg || (state_reg == DPA_SEND)) else $error("info not due");
	a_async_ratio: assert property (@(posedge clk) disable iff (!rstn) // R21
		!misc_sync_reg ##1 !misc_sync_reg && $past(rstn) |-> (vid_n_out == VID_N_FIXED) && (vid_m_out == $past(vid_m_in)))
		else $error("async video ratio wrong");
	a_sync_ratio: assert property (@(posedge clk) disable iff (!rstn) // R20
		misc_sync_reg ##1 misc_sync_reg && $past(rstn) |-> (vid_m_out == $past(vid_num_reg)) && (audio_n_value == $past(aud_den_reg)))
		else $error("sync ratio wrong");
	a_ext_first: assert property (@(posedge clk) disable iff (!rstn) // R16
		(state_reg == DPA_IDLE) && ext_full && !start_info |=> (state_reg == DPA_SEND) && (kind_reg == DPA_K_EXT))
		else $error("extension packet not sent at first slot");
endmodule : dpa_packetizer
`default_nettype wire

//--- core/dpa_pkg.sv
// shared constants for the secondary-channel audio packetizer
`default_nettype none
package dpa_pkg;
	// register port geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// register offsets (byte addresses, one word each)
	localparam logic [7:0] OFS_AUDIO_CTRL = 8'h00;
	localparam logic [7:0] OFS_CHANNELS = 8'h04;
	localparam logic [7:0] OFS_INFO_DATA = 8'h08;
	localparam logic [7:0] OFS_AUD_NUM = 8'h0c;
	localparam logic [7:0] OFS_AUD_DEN = 8'h10;
	localparam logic [7:0] OFS_EXT_DATA = 8'h14;
	localparam logic [7:0] OFS_MISC = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1c;
	localparam logic [7:0] OFS_VID_NUM = 8'h20;
	localparam logic [7:0] OFS_VID_DEN = 8'h24;
	localparam logic [7:0] OFS_AUD_M_RD = 8'h28;
	// status bit positions
	localparam int ST_EXT_SENT = 0;
	localparam int ST_EXT_FULL = 1;
	localparam int ST_INFO_LOADED = 2;
	localparam int ST_SID_MISMATCH = 3;
	// packet geometry
	localparam logic [3:0] SAMPLES_PER_PKT = 4'h8;
	localparam logic [3:0] WORDS_PER_PKT = 4'h8;
	localparam logic [5:0] HDR_END = 6'h04;
	localparam logic [5:0] HDR_PAR_END = 6'h08;
	localparam logic [5:0] PAY_END = 6'h28;
	localparam logic [5:0] PKT_LAST = 6'h2f;
	// header type codes
	localparam logic [7:0] TYPE_AUDIO = 8'h02;
	localparam logic [7:0] TYPE_INFO = 8'h84;
	localparam logic [7:0] TYPE_EXT = 8'h85;
	// timing and ratio constants
	localparam int INFO_PERIOD_CYC = 8192;
	localparam int AUD_N_WINDOW_CYC = 32768;
	localparam logic [23:0] VID_N_FIXED = 24'h008000;
	// reset values
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	// packet engine states
	typedef enum logic [1:0] {
		DPA_IDLE = 2'b01,
		DPA_SEND = 2'b10
	} dpa_state_type;
	typedef enum logic [1:0] {
		DPA_K_AUDIO = 2'b00,
		DPA_K_INFO = 2'b01,
		DPA_K_EXT = 2'b10
	} dpa_kind_type;
endpackage : dpa_pkg
`default_nettype wire

//--- verif/dpa_audio_src.sv
// upstream audio source model feeding the packetizer stream port
`default_nettype none
module dpa_audio_src (
	input wire logic clk,
	input wire logic rstn,
	input wire logic slow,
	output logic [31:0] tdata,
	output logic [7:0] tid,
	output logic tvalid,
	input wire logic tready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] qd[$];
	logic [7:0] qt[$];
	logic gap;
	// queue one 32-bit word with its channel and stream id
	task automatic push(input logic [31:0] d, input logic [7:0] t);
		qd.push_back(d);
		qt.push_back(t);
	endtask : push
	// a word stays offered until taken; released lines show the inverse so stale data never looks valid
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tvalid <= 1'b0;
			tdata <= 32'h0;
			tid <= 8'h0;
			gap <= 1'b0;
		end else if (!tvalid || tready) begin
			gap <= ~gap;
			if (qd.size() != 0 && (!slow || gap)) begin
				tvalid <= 1'b1;
				tdata <= qd.pop_front();
				tid <= qt.pop_front();
			end else begin
				tvalid <= 1'b0;
				tdata <= ~tdata;
				tid <= ~tid;
			end
		end
	end
endmodule : dpa_audio_src
`default_nettype wire

//--- verif/tb_top.sv
// self-checking testbench of the secondary-channel packetizer
`default_nettype none
module tb_top
	import dpa_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rstn, reg_wr, reg_rd, tvalid, tready, aud_ref_clk, frame_start, slow;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, reg_rdata, r, v;
	logic [31:0] tdata, rnd, rdy_s;
	logic [7:0] tid, pkt_data;
	logic pkt_valid, pkt_sop, pkt_eop, pkt_ready, mute, irq;
	logic [23:0] vid_m_in, vid_m_out, vid_n_out, aud_m, aud_n;
	logic [7:0] pkt[48];
	logic [31:0] exp_q[$];
	int n_mismatch, n_checks, n_byte, n_pkts, n_irq, n0, i, j;

	dpa_packetizer #(.INFO_PERIOD(64), .AUD_WINDOW(256)) i_dpa_packetizer (
		.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .s_axis_audio_tdata(tdata), .s_axis_audio_tid(tid),
		.s_axis_audio_tvalid(tvalid), .s_axis_audio_tready(tready), .aud_ref_clk(aud_ref_clk),
		.frame_start(frame_start), .vid_m_in(vid_m_in), .pkt_data(pkt_data), .pkt_valid(pkt_valid),
		.pkt_sop(pkt_sop), .pkt_eop(pkt_eop), .pkt_ready(pkt_ready), .vertical_blank_identifier_mute(mute),
		.extension_packet_sent_irq(irq), .vid_m_out(vid_m_out), .vid_n_out(vid_n_out),
		.audio_m_value(aud_m), .audio_n_value(aud_n));
	dpa_audio_src i_dpa_audio_src (.clk(clk), .rstn(rstn), .slow(slow), .tdata(tdata), .tid(tid),
		.tvalid(tvalid), .tready(tready));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp_val
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : give_verdict
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task automatic send(input int n, input logic [3:0] sid);
		int k;
		for (k = 0; k < n; k++) begin
			rnd = lfsr(rnd);
			i_dpa_audio_src.push(rnd, {sid, 3'b000, k[0]});
			exp_q.push_back(rnd);
		end
	endtask : send
	task automatic wait_pkt(input int n, input int lim);
		int k;
		for (k = 0; k < lim && n_pkts == n; k++) @(posedge clk);
		cmp_val(n_pkts, n + 1);
	endtask : wait_pkt
	// payload bytes are the eight words, little endian
	task automatic cmp_pay();
		int k;
		for (k = 0; k < 8; k++) cmp_val({pkt[11+4*k], pkt[10+4*k], pkt[9+4*k], pkt[8+4*k]}, exp_q.pop_front());
	endtask : cmp_pay

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// reference clock unrelated to clk, well below half its rate
	initial begin
		aud_ref_clk = 1'b0;
		forever #43 aud_ref_clk = ~aud_ref_clk;
	end
	// link side: random stalls, and framing and parity checked on every packet
	always @(posedge clk) begin
		if (irq === 1'b1) n_irq++;
		if (pkt_valid === 1'b1 && pkt_ready === 1'b1) begin
			cmp_val(pkt_sop, n_byte == 0);
			cmp_val(pkt_eop, n_byte == 47);
			if (n_byte < 48) pkt[n_byte] = pkt_data;
			n_byte++;
			if (pkt_eop === 1'b1) begin
				for (j = 0; j < 4; j++) cmp_val(pkt[4+j], pkt[j] ^ pkt[(j+1)%4]);
				for (j = 0; j < 8; j++) cmp_val(pkt[40+j], pkt[8+j] ^ pkt[16+j] ^ pkt[24+j] ^ pkt[32+j]);
				n_byte = 0;
				n_pkts++;
			end
		end
		rdy_s = lfsr(rdy_s);
		pkt_ready <= rdy_s[1:0] != 2'b00;
	end
	initial begin
		repeat (12000) @(posedge clk);
		n_mismatch++;
		give_verdict();
	end

	initial begin
		rstn = 1'b0; reg_addr = 8'h0; reg_wdata = 32'h0; reg_wr = 1'b0; reg_rd = 1'b0; slow = 1'b0;
		frame_start = 1'b0; vid_m_in = 24'h0; pkt_ready = 1'b0; rnd = 32'h15f2; rdy_s = 32'h15f2;
		n_mismatch = 0; n_checks = 0; n_byte = 0; n_pkts = 0; n_irq = 0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		#1 cmp_val(mute, 1'b1);
		cmp_val(tready, 1'b0);
		cmp_val(pkt_valid, 1'b0);
		$display("test reset done");
		wr(OFS_CHANNELS, 32'h1);
		rd(OFS_CHANNELS, r);
		cmp_val(r[2:0], 3'h1);
		rd(8'hfc, r);
		cmp_val(r, 32'h0);
		// synchronous then asynchronous ratio sources
		wr(OFS_MISC, 32'h1);
		rnd = lfsr(rnd);
		wr(OFS_VID_NUM, rnd[23:0]);
		wr(OFS_VID_DEN, rnd[31:8]);
		wr(OFS_AUD_NUM, rnd[27:4]);
		wr(OFS_AUD_DEN, rnd[25:2]);
		repeat (3) @(posedge clk);
		cmp_val(vid_m_out, rnd[23:0]);
		cmp_val(vid_n_out, rnd[31:8]);
		cmp_val(aud_m, rnd[27:4]);
		cmp_val(aud_n, rnd[25:2]);
		wr(OFS_MISC, 32'h0);
		vid_m_in <= rnd[23:0] ^ 24'h5a5a5a;
		repeat (3) @(posedge clk);
		cmp_val(vid_m_out, rnd[23:0] ^ 24'h5a5a5a);
		cmp_val(vid_n_out, VID_N_FIXED);
		$display("test ratio done");
		// partial fill, disable flushes it, words wait while disabled
		wr(OFS_AUDIO_CTRL, 32'h1);
		repeat (2) @(posedge clk);
		cmp_val(mute, 1'b0);
		send(4, 4'h0);
		for (i = 0; i < 40 && (tvalid || i_dpa_audio_src.qd.size() != 0); i++) @(posedge clk);
		rd(OFS_STATUS, r);
		cmp_val(r[7:4], 4'h4);
		wr(OFS_AUDIO_CTRL, 32'h0);
		repeat (2) @(posedge clk);
		cmp_val(mute, 1'b1);
		exp_q.delete();
		n0 = n_pkts;
		slow <= 1'b1;
		send(8, 4'h0);
		repeat (30) @(posedge clk);
		cmp_val(tready, 1'b0);
		cmp_val(n_pkts, n0);
		wr(OFS_AUDIO_CTRL, 32'h1);
		wait_pkt(n0, 400);
		cmp_pay();
		// two packets back to back at full rate
		slow <= 1'b0;
		send(16, 4'h0);
		wait_pkt(n0 + 1, 400);
		cmp_pay();
		wait_pkt(n0 + 2, 400);
		cmp_pay();
		$display("test audio done");
		// extension packet; a ninth word finds the buffer full
		n0 = n_pkts;
		v = n_irq;
		for (i = 0; i < 9; i++) begin
			rnd = lfsr(rnd);
			if (i < 8) exp_q.push_back(rnd);
			wr(OFS_EXT_DATA, rnd);
		end
		wait_pkt(n0, 400);
		cmp_pay();
		repeat (5) @(posedge clk);
		cmp_val(n_irq, v + 1);
		rd(OFS_STATUS, r);
		cmp_val(r[ST_EXT_SENT], 1'b1);
		wr(OFS_STATUS, 32'h9);
		rd(OFS_STATUS, r);
		cmp_val(r[ST_EXT_SENT], 1'b0);
		repeat (150) @(posedge clk);
		cmp_val(n_pkts, n0 + 1);
		$display("test extension done");
		// info packet as soon as loaded while already due, then again after a frame pulse
		for (i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			v = (i == 0) ? {rnd[31:4], 4'h3} : rnd;
			exp_q.push_back(v);
			wr(OFS_INFO_DATA, v);
		end
		rd(OFS_STATUS, r);
		cmp_val(r[ST_INFO_LOADED], 1'b1);
		n0 = n_pkts;
		@(posedge clk);
		frame_start <= 1'b1;
		@(posedge clk);
		frame_start <= 1'b0;
		wait_pkt(n0, 200);
		for (i = 0; i < 8; i++) exp_q.push_back(exp_q[i]);
		cmp_pay();
		wait_pkt(n0 + 1, 200);
		cmp_pay();
		// stream id differing from the info frame packet id is flagged
		i_dpa_audio_src.push(32'h1234_5678, 8'h50);
		repeat (10) @(posedge clk);
		rd(OFS_STATUS, r);
		cmp_val(r[ST_SID_MISMATCH], 1'b1);
		$display("test info done");
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
